// ===== erc_cfg.svh
// timing constants for the edge-latched rom read controller
`ifndef ERC_CFG_SVH
`define ERC_CFG_SVH

// ****************************************
// clock
// ****************************************
`define ERC_CLK_PERIOD_NS      25

// ****************************************
// timing figures in ns, faster grade
// ****************************************
`define ERC_ADDR_SETUP_NS      0
`define ERC_ADDR_HOLD_NS       60
`define ERC_SEL_LOW_MIN_NS     250
`define ERC_SEL_LOW_MAX_NS     7500
`define ERC_ACCESS_NS          250
`define ERC_RELEASE_NS         60
`define ERC_RECOVERY_NS        125
`define ERC_PERIOD_NS          375

// ****************************************
// cycle counts, least times rounded up
// ****************************************
`define ERC_CEIL(t) (((t) + `ERC_CLK_PERIOD_NS - 1) / `ERC_CLK_PERIOD_NS)
`define ERC_FLOOR(t) ((t) / `ERC_CLK_PERIOD_NS)
`define ERC_HOLD_CYC      `ERC_CEIL(`ERC_ADDR_HOLD_NS)
`define ERC_LOW_CYC       `ERC_CEIL(`ERC_SEL_LOW_MIN_NS)
`define ERC_LOW_MAX_CYC   `ERC_FLOOR(`ERC_SEL_LOW_MAX_NS)
`define ERC_ACCESS_CYC    `ERC_CEIL(`ERC_ACCESS_NS)
`define ERC_RECOV_CYC     `ERC_CEIL(`ERC_RECOVERY_NS)
`define ERC_PERIOD_CYC    `ERC_CEIL(`ERC_PERIOD_NS)
`define ERC_RELEASE_CYC   `ERC_CEIL(`ERC_RELEASE_NS)

`define ERC_ADDR_W        13
`define ERC_DATA_W        8
`define ERC_CNT_W         10

`endif

// ===== erc_pkg.sv
// types for the edge-latched rom read controller
`default_nettype none
package erc_pkg;

  // ****************************************
  // controller states
  // ****************************************
  typedef enum logic [2:0] {
    ERC_IDLE,
    ERC_SETUP,
    ERC_LOW,
    ERC_RECOVER
  } erc_state_e;

  // ****************************************
  // pin group towards the rom
  // ****************************************
  typedef struct packed {
    logic        sel_n;
    logic [12:0] addr;
  } erc_pins_s;

endpackage : erc_pkg

`default_nettype wire

// ===== erc_sync.sv
// two flip-flop synchroniser for the rom data inputs
`timescale 1ns/100ps
`default_nettype none

module erc_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : erc_sync

`default_nettype wire

// ===== erc_ctrl.sv
// controller that reads words from an edge-latched 8k x 8 rom
`timescale 1ns/100ps
`default_nettype none
`include "erc_cfg.svh"

module erc_ctrl #(
  parameter int ADDR_W      = `ERC_ADDR_W,
  parameter int DATA_W      = `ERC_DATA_W,
  parameter int CNT_W       = `ERC_CNT_W,
  parameter int HOLD_CYC    = `ERC_HOLD_CYC,
  parameter int LOW_CYC     = `ERC_LOW_CYC,
  parameter int LOW_MAX_CYC = `ERC_LOW_MAX_CYC,
  parameter int ACCESS_CYC  = `ERC_ACCESS_CYC,
  parameter int RECOV_CYC   = `ERC_RECOV_CYC,
  parameter int PERIOD_CYC  = `ERC_PERIOD_CYC,
  parameter int RELEASE_CYC = `ERC_RELEASE_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  output var  logic              req_ready,
  output var  logic              rsp_valid,
  output var  logic [DATA_W-1:0] rsp_data,
  output var  logic              rom_sel_n,
  output var  logic [ADDR_W-1:0] rom_addr,
  input  wire logic [DATA_W-1:0] rom_data
);

  // ****************************************
  // timing limits at counter width
  // ****************************************
  localparam logic [CNT_W-1:0] HOLD_L  = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] SAMP_L  = CNT_W'(ACCESS_CYC + 2);
  localparam logic [CNT_W-1:0] LOW_L   =
    CNT_W'((LOW_CYC > ACCESS_CYC + 3) ? LOW_CYC : ACCESS_CYC + 3);
  localparam logic [CNT_W-1:0] REC_L   =
    CNT_W'((RECOV_CYC > RELEASE_CYC) ? RECOV_CYC : RELEASE_CYC);
  localparam logic [CNT_W-1:0] PER_L   = CNT_W'(PERIOD_CYC);
  localparam logic [CNT_W-1:0] LMAX_L  = CNT_W'(LOW_MAX_CYC);

  // ****************************************
  // decodes used in more than one place
  // ****************************************
  // low phase ends at the longer need, never past the width cap
  function automatic logic low_done(input logic [CNT_W-1:0] cnt);
    return (cnt >= LOW_L) || (cnt >= LMAX_L);
  endfunction : low_done

  // ****************************************
  // state and counters
  // ****************************************
  erc_pkg::erc_state_e state_q;
  logic [CNT_W-1:0]    low_cnt_q;
  logic [CNT_W-1:0]    high_cnt_q;
  logic [CNT_W-1:0]    per_cnt_q;
  logic [ADDR_W-1:0]   next_addr_q;
  logic                pend_q;
  logic [DATA_W-1:0]   data_sync;
  logic                may_fall;
  logic [CNT_W-1:0]    hold_cnt_q;
  logic                hold_done;
  logic                sel_fall;
  logic                addr_load;

  // only this controller drives the single select line
  // rom is read only, so the controller has no data output path
  assign may_fall = (high_cnt_q >= REC_L) &&
                    (per_cnt_q >= PER_L);
  assign sel_fall  = (state_q == erc_pkg::ERC_SETUP) && may_fall;
  assign addr_load = (state_q == erc_pkg::ERC_IDLE) && pend_q && hold_done;

  erc_sync #(
    .W(DATA_W)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (rom_data),
    .dout (data_sync)
  );

  // ****************************************
  // state machine
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= erc_pkg::ERC_IDLE;
    end else begin
      unique case (state_q)
        erc_pkg::ERC_IDLE: begin
          if (addr_load) begin
            state_q <= erc_pkg::ERC_SETUP;
          end
        end
        erc_pkg::ERC_SETUP: begin
          if (may_fall) begin
            state_q <= erc_pkg::ERC_LOW;
          end
        end
        erc_pkg::ERC_LOW: begin
          if (low_done(low_cnt_q)) begin
            state_q <= erc_pkg::ERC_RECOVER;
          end
        end
        erc_pkg::ERC_RECOVER: begin
          state_q <= erc_pkg::ERC_IDLE;
        end
        default: begin
          state_q <= erc_pkg::ERC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // request capture
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_q      <= 1'b0;
      next_addr_q <= '0;
      req_ready   <= 1'b1;
    end else if (req_valid && req_ready) begin
      pend_q      <= 1'b1;
      next_addr_q <= req_addr;
      req_ready   <= 1'b0;
    end else if (sel_fall) begin
      pend_q      <= 1'b0;
    end else if (state_q == erc_pkg::ERC_RECOVER) begin
      req_ready   <= 1'b1;
    end
  end

  // ****************************************
  // pins towards the rom
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rom_sel_n <= 1'b1;
      rom_addr  <= '0;
    end else begin
      if (addr_load) begin
        rom_addr <= next_addr_q;
      end
      if (sel_fall) begin
        rom_sel_n <= 1'b0;
      end else if (state_q == erc_pkg::ERC_LOW && low_done(low_cnt_q)) begin
        rom_sel_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // interval counters
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_cnt_q  <= '0;
      high_cnt_q <= REC_L;
      per_cnt_q  <= PER_L;
    end else begin
      if (!rom_sel_n) begin
        low_cnt_q  <= low_cnt_q + 1'b1;
        high_cnt_q <= '0;
      end else begin
        low_cnt_q <= '0;
        if (high_cnt_q < REC_L) begin
          high_cnt_q <= high_cnt_q + 1'b1;
        end
      end
      if (sel_fall) begin
        per_cnt_q <= CNT_W'(1);
      end else if (per_cnt_q < PER_L) begin
        per_cnt_q <= per_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // address hold after select falls
  // ****************************************
  // the next address may load only once the hold time has run
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_cnt_q <= HOLD_L;
    end else if (sel_fall) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q < HOLD_L) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  assign hold_done = (hold_cnt_q >= HOLD_L);

  // ****************************************
  // read data capture
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else if (!rom_sel_n && low_cnt_q == SAMP_L && SAMP_L > HOLD_L) begin
      rsp_valid <= 1'b1;
      rsp_data  <= data_sync;
    end else begin
      rsp_valid <= 1'b0;
    end
  end

endmodule : erc_ctrl

`default_nettype wire

// ===== erc_rom_model.sv
// behavioural model of the edge-latched 8k x 8 rom
`timescale 1ns/100ps
`default_nettype none
// ****
// rom model
// ****
module erc_rom_model (
  input  wire logic        sel_n,
  input  wire logic [12:0] addr,
  output wire logic [7:0]  data
);
  int          acc_ns = 250;
  logic [12:0] a_q;
  logic [7:0]  last = 8'h00;
  logic        on = 1'b0;
  function automatic logic [7:0] word(logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h2} ^ 8'h69;
  endfunction : word
  always @(negedge sel_n) begin
    a_q = addr;
    #(acc_ns);
    if (!sel_n) begin
      last = word(a_q);
      on = 1'b1;
    end
  end
  always @(posedge sel_n) begin
    #60;
    on = 1'b0;
  end
  assign data = on ? last : ~last;
endmodule : erc_rom_model
`default_nettype wire

// ===== erc_ctrl_sva.sv
// checker for the rom read controller pins
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module erc_ctrl_chk #(
  parameter int PERIOD_CYC  = 15,
  parameter int LOW_MAX_CYC = 300
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        rom_sel_n,
  input wire logic [12:0] rom_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  int low_q;
  int per_q;
  always_ff @(posedge mclk) begin
    if (rst || rom_sel_n) low_q <= 0;
    else low_q <= low_q + 1;
  end
  always_ff @(posedge mclk) begin
    if (rst) per_q <= PERIOD_CYC;
    else if ($fell(rom_sel_n)) per_q <= 1;
    else if (per_q < 1000) per_q <= per_q + 1;
  end
  a_addr_setup: assert property (
    $fell(rom_sel_n) |-> $stable(rom_addr))
    else $error("address moved at select fall");
  a_addr_hold: assert property (
    $fell(rom_sel_n) |=> $stable(rom_addr)[*3])
    else $error("address changed in hold time");
  a_sel_min: assert property (
    $fell(rom_sel_n) |-> !rom_sel_n[*8] ##1 !rom_sel_n[*2])
    else $error("select low too short");
  a_sel_max: assert property (low_q <= LOW_MAX_CYC)
    else $error("select low too long");
  a_sel_recover: assert property ($rose(rom_sel_n) |-> rom_sel_n[*5])
    else $error("select high too short");
  a_fall_period: assert property (
    $fell(rom_sel_n) |-> per_q >= PERIOD_CYC)
    else $error("select falls too close");
  a_one_select: assert property (!rom_sel_n |-> !req_ready)
    else $error("request open while selected");
  a_rsp_after: assert property (
    $fell(rom_sel_n) |-> ##[10:16] rsp_valid)
    else $error("read data late or early");
  c_fall: cover property ($fell(rom_sel_n));
  c_rsp: cover property (rsp_valid);
  c_refuse: cover property (req_valid && !req_ready);
endmodule : erc_ctrl_chk
bind erc_ctrl erc_ctrl_chk #(
  .PERIOD_CYC  (PERIOD_CYC),
  .LOW_MAX_CYC (LOW_MAX_CYC)
) i_chk (
  .mclk      (mclk),
  .rst       (rst),
  .req_valid (req_valid),
  .req_ready (req_ready),
  .rsp_valid (rsp_valid),
  .rom_sel_n (rom_sel_n),
  .rom_addr  (rom_addr)
);
`default_nettype wire

// ===== test_erc_ctrl.sv
// testbench for the rom read controller
`timescale 1ns/100ps
`default_nettype none
// ****
// testbench
// ****
module test_erc_ctrl;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [12:0] req_addr = 13'h0000;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rom_sel_n;
  logic [12:0] rom_addr;
  wire  [7:0]  rom_data;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [15:0] seed = 16'h0003;
  logic [12:0] cur;
  logic [12:0] nxt;
  always #12.5 mclk = ~mclk;
  erc_ctrl i_erc_ctrl (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_addr(req_addr), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rom_sel_n(rom_sel_n), .rom_addr(rom_addr),
    .rom_data(rom_data));
  erc_rom_model i_erc_rom_model (.sel_n(rom_sel_n), .addr(rom_addr),
    .data(rom_data));
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [7:0] exp_word(logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h2} ^ 8'h69;
  endfunction : exp_word
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [12:0] a, b, input logic keep);
    int   i;
    logic got;
    got = 1'b0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_addr <= a;
    for (i = 0; i < 60 && !got; i++) begin
      @(posedge mclk);
      got = (req_ready === 1'b1);
    end
    req_valid <= 1'b0;
    got = 1'b0;
    for (i = 0; i < 60 && !got; i++) begin
      @(posedge mclk);
      if (i == 3 && keep) begin
        req_valid <= 1'b1;
        req_addr <= b;
      end
      #1 got = (rsp_valid === 1'b1);
    end
    chk("rsp_seen", {15'h0000, got}, 16'h0001);
    chk("rsp_data", {8'h00, rsp_data}, {8'h00, exp_word(a)});
    @(posedge mclk);
    #1 chk("rsp_pulse", {15'h0000, rsp_valid}, 16'h0000);
  endtask : rd
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk("reset_pins", {req_ready, rom_sel_n, rsp_valid}, 16'h0006);
    chk("reset_data", {8'h00, rsp_data}, 16'h0000);
    chk("rom_addr", {3'h0, rom_addr}, 16'h0000);
    rd(13'h0000, 13'h0000, 1'b0);
    rd(13'h1fff, 13'h1fff, 1'b0);
    rd(13'h0aaa, 13'h1555, 1'b1);
    rd(13'h1555, 13'h1555, 1'b0);
    cur = 13'h0123;
    for (int k = 0; k < 40; k++) begin
      if (k == 20) i_erc_rom_model.acc_ns = 50;
      seed = lfsr(seed);
      nxt = seed[12:0];
      rd(cur, nxt, seed[13]);
      cur = nxt;
    end
    rd(cur, cur, 1'b0);
    stop_test();
  end
endmodule : test_erc_ctrl
`default_nettype wire
